// >>> design/sfm_monitor.sv
`include "sfm_params.svh"

// Behaviour
// - Bridge closed at power-up before control.
// - Set-point outside 15..85 percent is error.
// - Floating set-point means neutral demand.
// - Broken or shorted transducer wiring is error.
// - Spool beyond demand or opposite side errors.
// - Nearer neutral on same side is fine.
// - Float entry and exit timeouts on six-pin.
// - Active or passive reaction, same error set.
// - Active reacts after 500 ms, orifice 750.
// - Active fault disables whole solenoid bridge.
// - Fault drives error output and red LED.
// - Active fault latches until reboot.
// - Passive reacts after 250 ms, orifice 750.
// - Passive fault keeps bridge and loop running.
// - Passive fault drives error, direction outputs low.
// - Passive fault holds 100 ms, then self-clears once no error remains.
// - Drive valves from set-point minus position.
module sfm_monitor
	import sfm_pkg::*;
#(
	parameter int AW = 12,
	parameter int DEADBAND = 16,
	parameter int DIR_HI = 64,
	parameter int DIR_LO = 32,
	parameter int TICK_CYC = `SFM_TICK_CYC
) (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rst,
	// Register bus.
	input wire logic [3:0] bus_addr,
	input wire logic [15:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [15:0] bus_rdata,
	// Analog converter samples, unsigned, full scale equals supply.
	input wire logic [AW-1:0] control_setpoint_input,
	input wire logic setpoint_floating,
	input wire logic [AW-1:0] spool_position,
	input wire logic transducer_open,
	input wire logic transducer_short,
	// Float handshake pins.
	input wire logic float_request,
	input wire logic float_reached,
	// Actuator and indicator outputs.
	output sfm_bridge_s bridge,
	output logic error_out,
	output logic led_red,
	output logic led_green,
	output logic [1:0] direction_indicator_outputs,
	output logic irq
);

	localparam logic [AW-1:0] NEUTRAL = AW'(1 << (AW - 1));
	localparam logic [AW-1:0] FULL = {AW{1'b1}};
	localparam logic [AW-1:0] SP_LO = AW'((2 ** AW) * `SFM_SP_LOW_PCT / 100);
	localparam logic [AW-1:0] SP_HI = AW'((2 ** AW) * `SFM_SP_HIGH_PCT / 100);
	localparam int TW = 10;
	localparam int CW = $clog2(TICK_CYC + 1);

	// Two-flop synchronisers for every pin-side input.
	logic [AW-1:0] sp_s1, sp_s2, pos_s1, pos_s2;
	logic [4:0] pin_s1, pin_s2;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sp_s1 <= '0;
			sp_s2 <= '0;
			pos_s1 <= '0;
			pos_s2 <= '0;
			pin_s1 <= '0;
			pin_s2 <= '0;
		end else begin
			sp_s1 <= control_setpoint_input;
			sp_s2 <= sp_s1;
			pos_s1 <= spool_position;
			pos_s2 <= pos_s1;
			pin_s1 <= {setpoint_floating, transducer_open, transducer_short,
				float_request, float_reached};
			pin_s2 <= pin_s1;
		end
	end

	logic sp_float, xdcr_open, xdcr_short, flt_req, flt_done;
	assign {sp_float, xdcr_open, xdcr_short, flt_req, flt_done} = pin_s2;

	// Millisecond tick prescaler.
	logic [CW-1:0] pre_reg;
	logic ms_tick;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pre_reg <= '0;
		end else if (pre_reg == CW'(TICK_CYC - 1)) begin
			pre_reg <= '0;
		end else begin
			pre_reg <= pre_reg + CW'(1);
		end
	end
	assign ms_tick = (pre_reg == CW'(TICK_CYC - 1));

	// Control register: software picks the build variant.
	logic [7:0] ctrl_reg;
	logic passive_mode, orifice_var, float_var, dir_var;
	assign passive_mode = ctrl_reg[`SFM_CTRL_PASSIVE];
	assign orifice_var = ctrl_reg[`SFM_CTRL_ORIFICE];
	assign float_var = ctrl_reg[`SFM_CTRL_FLOAT_VAR];
	assign dir_var = ctrl_reg[`SFM_CTRL_DIR_IND];

	// Effective demand; a floating input is taken as neutral.
	logic [AW-1:0] demand;
	assign demand = sp_float ? NEUTRAL : sp_s2;

	// Set-point window check, skipped while floating.
	logic err_sp;
	assign err_sp = !sp_float && (sp_s2 < SP_LO || sp_s2 > SP_HI);

	// Transducer wiring check.
	logic err_xdcr;
	assign err_xdcr = xdcr_open || xdcr_short;

	// Loop check: beyond demand or wrong side of neutral is an error.
	logic dem_pos, act_pos, dem_neu, act_neu;
	logic [AW-1:0] dem_mag, act_mag;
	logic err_loop;
	always_comb begin
		dem_pos = demand > NEUTRAL;
		act_pos = spool_pos_gt_neutral(pos_s2);
		dem_mag = dem_pos ? demand - NEUTRAL : NEUTRAL - demand;
		act_mag = act_pos ? pos_s2 - NEUTRAL : NEUTRAL - pos_s2;
		dem_neu = dem_mag <= AW'(DEADBAND);
		act_neu = act_mag <= AW'(DEADBAND);
		err_loop = 1'b0;
		if (!act_neu && !dem_neu && act_pos != dem_pos) begin
			err_loop = 1'b1;
		end else if (act_mag > dem_mag + AW'(DEADBAND)) begin
			err_loop = 1'b1;
		end
		// Nearer to neutral on the same side stays in control.
	end

	function automatic logic spool_pos_gt_neutral(input logic [AW-1:0] p);
		return p > NEUTRAL;
	endfunction

	// Float timing: request pending without completion times out.
	logic flt_req_d, entering_reg, leaving_reg;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			flt_req_d <= 1'b0;
			entering_reg <= 1'b0;
			leaving_reg <= 1'b0;
		end else begin
			flt_req_d <= flt_req;
			if (flt_req && !flt_req_d) begin
				entering_reg <= 1'b1;
				leaving_reg <= 1'b0;
			end else if (!flt_req && flt_req_d) begin
				leaving_reg <= 1'b1;
				entering_reg <= 1'b0;
			end else begin
				if (flt_done) begin
					entering_reg <= 1'b0;
				end
				if (!flt_done) begin
					leaving_reg <= 1'b0;
				end
			end
		end
	end

	logic fe_exp, fx_exp, err_float;
	sfm_persist_timer #(.W(TW)) u_float_entry (
		.sys_clk(sys_clk),
		.rst(rst),
		.ms_tick(ms_tick),
		.cond(float_var && entering_reg),
		.limit(TW'(`SFM_FLOAT_ENTRY_MS)),
		.expired(fe_exp)
	);
	sfm_persist_timer #(.W(TW)) u_float_exit (
		.sys_clk(sys_clk),
		.rst(rst),
		.ms_tick(ms_tick),
		.cond(float_var && leaving_reg),
		.limit(TW'(`SFM_FLOAT_EXIT_MS)),
		.expired(fx_exp)
	);
	assign err_float = fe_exp || fx_exp;

	// One error set feeds both reaction versions.
	logic any_err;
	assign any_err = err_sp || err_xdcr || err_loop || err_float;

	// Reaction delay by version and variant.
	logic [TW-1:0] react_lim;
	always_comb begin
		if (orifice_var) begin
			react_lim = TW'(`SFM_ORIFICE_MS);
		end else if (passive_mode) begin
			react_lim = TW'(`SFM_PASSIVE_MS);
		end else begin
			react_lim = TW'(`SFM_ACTIVE_MS);
		end
	end

	logic react_exp;
	sfm_persist_timer #(.W(TW)) u_react (
		.sys_clk(sys_clk),
		.rst(rst),
		.ms_tick(ms_tick),
		.cond(any_err),
		.limit(react_lim),
		.expired(react_exp)
	);

	// Fault supervisor; the latched state is left only by reset.
	sfm_state_e state_reg;
	logic [TW-1:0] hold_reg;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_reg <= SFM_ST_INIT;
			hold_reg <= '0;
		end else begin
			case (state_reg)
				SFM_ST_INIT: begin
					state_reg <= SFM_ST_RUN;
				end
				SFM_ST_RUN: begin
					hold_reg <= '0;
					if (react_exp) begin
						state_reg <= passive_mode ? SFM_ST_WARN
							: SFM_ST_LATCHED;
					end
				end
				SFM_ST_LATCHED: begin
					state_reg <= SFM_ST_LATCHED;
				end
				SFM_ST_WARN: begin
					if (ms_tick && hold_reg < TW'(`SFM_PASSIVE_HOLD_MS)) begin
						hold_reg <= hold_reg + TW'(1);
					end
					if (hold_reg >= TW'(`SFM_PASSIVE_HOLD_MS) && !any_err) begin
						state_reg <= SFM_ST_RUN;
					end
				end
				default: begin
					state_reg <= SFM_ST_INIT;
				end
			endcase
		end
	end

	logic faulted, drive_en;
	assign faulted = state_reg == SFM_ST_LATCHED || state_reg == SFM_ST_WARN;
	// Passive warning keeps the loop running.
	assign drive_en = state_reg == SFM_ST_RUN || state_reg == SFM_ST_WARN;

	// Closed-loop regulation: open the pair that pushes toward demand.
	// The error is one bit wider, so a spool near either end cannot wrap.
	localparam int LW = AW + 1;
	logic [AW:0] loop_err;
	assign loop_err = {1'b0, demand} - {1'b0, pos_s2};
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			bridge <= '0;
		end else if (!drive_en) begin
			bridge <= '0;
		end else begin
			bridge <= '0;
			if (!loop_err[AW] && loop_err > LW'(DEADBAND)) begin
				bridge.nc1 <= 1'b1;
				bridge.no4 <= 1'b1;
			end else if (loop_err[AW]
				&& loop_err < LW'((2 ** LW) - DEADBAND)) begin
				bridge.nc3 <= 1'b1;
				bridge.no2 <= 1'b1;
			end
		end
	end

	// Indicators, all registered.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			error_out <= 1'b0;
			led_red <= 1'b0;
			led_green <= 1'b0;
			direction_indicator_outputs <= 2'h0;
		end else begin
			error_out <= faulted;
			led_red <= faulted;
			led_green <= !faulted;
			if (!dir_var || faulted) begin
				direction_indicator_outputs <= 2'h0;
			end else begin
				direction_indicator_outputs[0] <=
					!(pos_s2 < NEUTRAL - AW'(DIR_HI));
				direction_indicator_outputs[1] <=
					!(pos_s2 > NEUTRAL + AW'(DIR_HI));
			end
		end
	end

	// Sticky interrupt status; a new event wins over a clear.
	logic [4:0] irq_stat_reg, irq_mask_reg, ev;
	logic faulted_d;
	assign ev = {faulted && !faulted_d, err_float, err_loop, err_xdcr, err_sp};
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			irq_stat_reg <= '0;
			irq_mask_reg <= '0;
			ctrl_reg <= `SFM_CTRL_RESET;
			faulted_d <= 1'b0;
		end else begin
			faulted_d <= faulted;
			irq_stat_reg <= (irq_stat_reg & ~((bus_wr && bus_addr ==
				`SFM_ADDR_IRQ_STAT) ? bus_wdata[4:0] : 5'h00)) | ev;
			if (bus_wr && bus_addr == `SFM_ADDR_IRQ_MASK) begin
				irq_mask_reg <= bus_wdata[4:0];
			end
			// Variant is only changed while no fault is active.
			if (bus_wr && bus_addr == `SFM_ADDR_CTRL && !faulted) begin
				ctrl_reg <= bus_wdata[7:0];
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat_reg & irq_mask_reg);
		end
	end

	// Read data one cycle after the strobe; unmapped reads zero.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			bus_rdata <= 16'h0000;
		end else if (bus_rd) begin
			case (bus_addr)
				`SFM_ADDR_CTRL: bus_rdata <= {8'h00, ctrl_reg};
				`SFM_ADDR_STATUS: bus_rdata <= {8'h00, 2'(state_reg),
					1'b0, any_err, err_float, err_loop, err_xdcr, err_sp};
				`SFM_ADDR_IRQ_STAT: bus_rdata <= {11'h000, irq_stat_reg};
				`SFM_ADDR_IRQ_MASK: bus_rdata <= {11'h000, irq_mask_reg};
				`SFM_ADDR_SETPOINT: bus_rdata <= 16'(demand);
				`SFM_ADDR_POSITION: bus_rdata <= 16'(pos_s2);
				default: bus_rdata <= 16'h0000;
			endcase
		end else begin
			bus_rdata <= 16'h0000;
		end
	end

endmodule

// >>> inc/sfm_params.svh
`ifndef SFM_PARAMS_SVH
`define SFM_PARAMS_SVH

// Clock rate and millisecond tick prescale.
`define SFM_CLK_HZ 10000000
`define SFM_TICK_CYC (`SFM_CLK_HZ / 1000)

// Set-point window in percent of supply.
`define SFM_SP_LOW_PCT 15
`define SFM_SP_HIGH_PCT 85

// Reaction delays in milliseconds.
`define SFM_ACTIVE_MS 500
`define SFM_PASSIVE_MS 250
`define SFM_ORIFICE_MS 750
`define SFM_PASSIVE_HOLD_MS 100

// Float timeouts in milliseconds.
`define SFM_FLOAT_ENTRY_MS 500
`define SFM_FLOAT_EXIT_MS 750

// Register offsets.
`define SFM_ADDR_CTRL 4'h0
`define SFM_ADDR_STATUS 4'h1
`define SFM_ADDR_IRQ_STAT 4'h2
`define SFM_ADDR_IRQ_MASK 4'h3
`define SFM_ADDR_SETPOINT 4'h4
`define SFM_ADDR_POSITION 4'h5

// Control field positions and reset value.
`define SFM_CTRL_PASSIVE 0
`define SFM_CTRL_ORIFICE 1
`define SFM_CTRL_FLOAT_VAR 2
`define SFM_CTRL_DIR_IND 3
`define SFM_CTRL_RESET 8'h00

// Interrupt status bit positions.
`define SFM_IRQ_SP 0
`define SFM_IRQ_XDCR 1
`define SFM_IRQ_LOOP 2
`define SFM_IRQ_FLOAT 3
`define SFM_IRQ_FAULT 4

`endif

// >>> inc/sfm_pkg.sv
package sfm_pkg;

	// Fault supervisor states.
	typedef enum logic [1:0] {
		SFM_ST_INIT,
		SFM_ST_RUN,
		SFM_ST_LATCHED,
		SFM_ST_WARN
	} sfm_state_e;

	// Solenoid bridge command: two normally closed, two normally open.
	typedef struct packed {
		logic nc1;
		logic nc3;
		logic no2;
		logic no4;
	} sfm_bridge_s;

	// Register bus request.
	typedef struct packed {
		logic [3:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} sfm_bus_s;

	typedef logic [4:0] sfm_err_t;

endpackage

// >>> design/sfm_persist_timer.sv
`include "sfm_params.svh"

// Counts millisecond ticks while its condition holds; any gap restarts it.
module sfm_persist_timer
	import sfm_pkg::*;
#(
	parameter int W = 10
) (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rst,
	// Control.
	input wire logic ms_tick,
	input wire logic cond,
	input wire logic [W-1:0] limit,
	// Result.
	output logic expired
);

	logic [W-1:0] count_reg;

	// Restarting on a clear filters short glitches from the sensors.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			count_reg <= '0;
		end else if (!cond) begin
			count_reg <= '0;
		end else if (ms_tick && count_reg < limit) begin
			count_reg <= count_reg + W'(1);
		end
	end

	assign expired = cond && (count_reg >= limit);

endmodule

// >>> dv/sfm_spool_model.sv
// Spool and transducer behind the valve bridge; jam pins the spool anywhere.
module sfm_spool_model
	import sfm_pkg::*;
(
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rst,
	// Bridge command and scenario control.
	input wire sfm_bridge_s bridge,
	input wire logic jam,
	input wire logic [11:0] jam_pos,
	// Measured position.
	output logic [11:0] spool_position
);
	timeunit 1ns;
	timeprecision 1ns;

	// Pilot pressure moves the spool; with the bridge shut the spring recentres it.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			spool_position <= 12'h800;
		end else if (jam) begin
			spool_position <= jam_pos;
		end else if (bridge.nc1 && bridge.no4) begin
			spool_position <= spool_position + 12'h004;
		end else if (bridge.nc3 && bridge.no2) begin
			spool_position <= spool_position - 12'h004;
		end else if (spool_position > 12'h800) begin
			spool_position <= spool_position - 12'h001;
		end else if (spool_position < 12'h800) begin
			spool_position <= spool_position + 12'h001;
		end
	end
endmodule

// >>> dv/sfm_monitor_properties.sv
// Watches the monitor's pins; the mode bits are shadowed from bus writes.
module sfm_monitor_checker
	import sfm_pkg::*;
#(
	parameter int TICK_CYC = 10
) (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rst,
	// Register writes.
	input wire logic [3:0] bus_addr,
	input wire logic [15:0] bus_wdata,
	input wire logic bus_wr,
	// Wiring fault pins.
	input wire logic transducer_open,
	input wire logic transducer_short,
	// Outputs.
	input wire sfm_bridge_s bridge,
	input wire logic error_out,
	input wire logic led_red,
	input wire logic led_green,
	input wire logic [1:0] direction_indicator_outputs
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	logic [3:0] ctrl_reg;
	int pin_cnt;
	int hold_cnt;

	// Mode shadow; writes during a fault are refused, so they are skipped.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ctrl_reg <= 4'h0;
		end else if (bus_wr && bus_addr == 4'h0 && !error_out) begin
			ctrl_reg <= bus_wdata[3:0];
		end
	end

	// Cycles of an unbroken wiring fault and of a standing fault output.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pin_cnt <= 0;
			hold_cnt <= 0;
		end else begin
			pin_cnt <= (transducer_open || transducer_short) ? pin_cnt + 1 : 0;
			hold_cnt <= error_out ? hold_cnt + 1 : 0;
		end
	end

	chk_reset_closed: assert property (
		$fell(rst) |=> bridge == 4'h0 && !error_out)
		else $error("bridge open right after reset");
	chk_fault_led: assert property (
		error_out |-> led_red && !led_green)
		else $error("fault shown without red lamp");
	chk_fault_dir: assert property (
		error_out |-> direction_indicator_outputs == 2'b00)
		else $error("direction outputs high during fault");
	chk_active_off: assert property (
		error_out && !ctrl_reg[0] |-> bridge == 4'h0)
		else $error("bridge driven in active fault");
	chk_fault_latch: assert property (
		error_out && !ctrl_reg[0] |=> error_out [*8])
		else $error("active fault released");
	chk_active_delay: assert property (
		ctrl_reg[1:0] == 2'b00 && pin_cnt == 500 * TICK_CYC + 30 |-> error_out)
		else $error("active fault late");
	chk_passive_delay: assert property (
		ctrl_reg[1:0] == 2'b01 && pin_cnt == 250 * TICK_CYC + 30 |-> error_out)
		else $error("passive fault late");
	chk_passive_hold: assert property (
		$fell(error_out) && ctrl_reg[0] |-> hold_cnt >= 99 * TICK_CYC)
		else $error("passive fault cleared too soon");
	chk_bridge_dir: assert property (
		!(bridge.nc1 && bridge.nc3))
		else $error("bridge pushes both ways");
endmodule

bind sfm_monitor sfm_monitor_checker #(.TICK_CYC(TICK_CYC)) i_chk (
	.sys_clk(sys_clk), .rst(rst), .bus_addr(bus_addr),
	.bus_wdata(bus_wdata), .bus_wr(bus_wr),
	.transducer_open(transducer_open), .transducer_short(transducer_short),
	.bridge(bridge), .error_out(error_out), .led_red(led_red),
	.led_green(led_green),
	.direction_indicator_outputs(direction_indicator_outputs)
);

// >>> dv/spool_actuator_fault_monitor_test.sv
module spool_actuator_fault_monitor_test
	import sfm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk, rst, bus_wr, bus_rd, flt, xo, xs, freq, frch, jam;
	logic [3:0] bus_addr;
	logic [15:0] bus_wdata, bus_rdata;
	logic [11:0] sp, pos, jam_pos;
	logic error_out, led_red, led_green, irq;
	logic [1:0] dio;
	sfm_bridge_s bridge;
	int n_errors = 0;
	int checked = 0;
	// Per test: mode bits and expected reaction in ms, zero for no fault.
	logic [3:0] t_ctrl [9] = '{4'h0, 4'h2, 4'h1, 4'h3, 4'h9,
		4'h0, 4'h0, 4'h0, 4'h5};
	int t_ms [9] = '{500, 750, 250, 750, 250, 0, 0, 0, 750};

	// Short tick prescale keeps the millisecond delays affordable.
	sfm_monitor #(.TICK_CYC(10)) i_dut (
		.sys_clk(sys_clk), .rst(rst), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
		.bus_rdata(bus_rdata), .control_setpoint_input(sp),
		.setpoint_floating(flt), .spool_position(pos),
		.transducer_open(xo), .transducer_short(xs),
		.float_request(freq), .float_reached(frch), .bridge(bridge),
		.error_out(error_out), .led_red(led_red), .led_green(led_green),
		.direction_indicator_outputs(dio), .irq(irq)
	);

	sfm_spool_model i_spool (
		.sys_clk(sys_clk), .rst(rst), .bridge(bridge), .jam(jam),
		.jam_pos(jam_pos), .spool_position(pos)
	);

	// Free-running 10 MHz clock.
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	// Spool within the settling band of the loop around a demand.
	function automatic bit near(input logic [11:0] a, input logic [11:0] b);
		return (a > b ? a - b : b - a) <= 12'h030;
	endfunction

	// Bus cycles start right after a rising edge; the gap edge avoids
	// a second strobe assignment in the same time step.
	task automatic bwr(input logic [3:0] a, input logic [15:0] d);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge sys_clk);
		bus_wr <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic brd(input logic [3:0] a, output logic [15:0] d);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge sys_clk);
		bus_rd <= 1'b0;
		@(negedge sys_clk);
		d = bus_rdata;
		@(posedge sys_clk);
	endtask

	// Bounded wait for the fault output to reach a level.
	task automatic await(input logic v, input int lim);
		int i;
		logic ok;
		for (i = 0; i < lim; i++) begin
			@(negedge sys_clk);
			if (error_out === v) break;
		end
		ok = error_out === v;
		check(error_out, v);
		@(posedge sys_clk);
		if (!ok) tally_and_finish();
	endtask

	// Applies or removes the fault source of test k.
	task automatic drive(input int k, input logic on);
		case (k)
			0, 7: xo <= on;
			1: begin
				sp <= 12'hC00;
				jam_pos <= 12'h600;
				jam <= on;
			end
			2: xs <= on;
			3: sp <= on ? 12'h200 : 12'h800;
			4: sp <= on ? 12'hE00 : 12'h800;
			5: begin
				flt <= on;
				sp <= 12'h000;
			end
			6: begin
				sp <= 12'hC00;
				jam_pos <= 12'hA00;
				jam <= on;
			end
			default: begin
				freq <= 1'b1;
				frch <= !on;
			end
		endcase
	endtask

	initial begin
		logic [15:0] d;
		int k;
		{rst, bus_wr, bus_rd, flt, xo, xs, freq, frch, jam} = 9'h100;
		{bus_addr, bus_wdata, sp, jam_pos} = {4'h0, 16'h0000, 12'h800, 12'h800};
		void'($urandom(32'hEEB77E5B));
		for (k = 0; k < 9; k++) begin
			{flt, xo, xs, freq, frch, jam} <= 6'h00;
			rst <= 1'b1;
			repeat (3) @(posedge sys_clk);
			rst <= 1'b0;
			@(posedge sys_clk);
			if (k == 0) begin
				brd(4'h0, d);
				check(d, 16'h0000);
				brd(4'hF, d);
				check(d, 16'h0000);
			end
			bwr(4'h0, {12'h000, t_ctrl[k]});
			bwr(4'h3, 16'h0000);
			sp <= 12'h300 + 12'($urandom % 32'h800);
			repeat (600) @(posedge sys_clk);
			drive(k, 1'b1);
			if (t_ms[k] == 0) begin
				if (k == 7) begin
					repeat (4000) @(posedge sys_clk);
					drive(k, 1'b0);
					repeat (30) @(posedge sys_clk);
					drive(k, 1'b1);
				end
				repeat (k == 7 ? 4000 : 5300) @(posedge sys_clk);
				@(negedge sys_clk);
				check(error_out, 1'b0);
				@(posedge sys_clk);
			end else begin
				repeat (t_ms[k] * 10 - 30) @(posedge sys_clk);
				@(negedge sys_clk);
				check(error_out, 1'b0);
				if (t_ctrl[k][3]) check(dio, 2'b01);
				@(posedge sys_clk);
				await(1'b1, 80);
				check({led_red, led_green, dio}, 16'h0008);
				check(irq, 1'b0);
				bwr(4'h3, 16'h0010);
				repeat (2) @(posedge sys_clk);
				@(negedge sys_clk);
				check(irq, 1'b1);
				@(posedge sys_clk);
				bwr(4'h2, 16'h0010);
				repeat (2) @(posedge sys_clk);
				@(negedge sys_clk);
				check(irq, 1'b0);
				@(posedge sys_clk);
				brd(4'h1, d);
				check(d & 16'h00C0, t_ctrl[k][0] ? 16'h00C0 : 16'h0080);
				if (t_ctrl[k][0]) begin
					repeat (100) @(posedge sys_clk);
					@(negedge sys_clk);
					check(near(pos, sp), 1'b1);
					@(posedge sys_clk);
				end
				drive(k, 1'b0);
				if (t_ctrl[k][0]) begin
					await(1'b0, 2000);
				end else begin
					repeat (2000) @(posedge sys_clk);
					@(negedge sys_clk);
					check(error_out, 1'b1);
					check(pos, 12'h800);
					@(posedge sys_clk);
				end
			end
			$display("test %0d done", k);
		end
		tally_and_finish();
	end
endmodule
